// ==== rtl/host_link_irq_mask_gate.sv ====
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "irq_mask_regs.svh"
//==========================================================================
// Interrupt mask stage
//==========================================================================
module host_link_irq_mask_gate (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Event register contents, same clock
    input  wire logic [31:0] event_i,
    // External interrupt request, level
    output logic             ext_irq_o,
    // Local status interrupt, level
    output logic             irq_o
);
    //======================================================================
    // Decode
    //======================================================================
    irq_mask_pkg::bus_req_s   req;     // Bundled request
    irq_mask_pkg::reg_sel_e   sel;     // Selected register
    logic [31:0]              mask;    // Stored mask
    logic                     ext_req; // Combined request
    logic [31:0]              rdata;      // Read data flops
    logic [31:0]              next_rdata; // Next read data
    logic [1:0]               stat;       // Sticky edge status
    logic [1:0]               next_stat;  // Next status
    logic [1:0]               stat_en;      // Status mask
    logic [1:0]               next_stat_en; // Next status mask
    logic                     ext_q;      // Output flop
    logic                     next_ext_q; // Next output

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Address to register select, used by both strobes
    function automatic irq_mask_pkg::reg_sel_e decode(input logic [7:0] a);
        unique case (a)
            `MASK_SET_OFS: decode = irq_mask_pkg::SEL_MASK_SET;
            `MASK_CLR_OFS: decode = irq_mask_pkg::SEL_MASK_CLR;
            `STAT_OFS:     decode = irq_mask_pkg::SEL_STAT;
            `STAT_EN_OFS:  decode = irq_mask_pkg::SEL_STAT_EN;
            default:       decode = irq_mask_pkg::SEL_NONE;
        endcase
    endfunction

    assign sel = decode(req.addr);

    //======================================================================
    // Mask storage and gate
    //======================================================================
    mask_store u_store (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .set_i     (req.wr && sel == irq_mask_pkg::SEL_MASK_SET),
        .clr_i     (req.wr && sel == irq_mask_pkg::SEL_MASK_CLR),
        .wdata_i   (req.wdata),
        .mask_o    (mask)
    );

    irq_gate u_gate (
        .mask_i  (mask),
        .event_i (event_i),
        .req_o   (ext_req)
    );

    //======================================================================
    // Read data, output flop and status
    //======================================================================
    // Read mux; unmapped reads return zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (req.rd) begin
            unique case (sel)
                irq_mask_pkg::SEL_MASK_SET,
                irq_mask_pkg::SEL_MASK_CLR: next_rdata = mask;
                irq_mask_pkg::SEL_STAT:     next_rdata = {30'h0, stat};
                irq_mask_pkg::SEL_STAT_EN:  next_rdata = {30'h0, stat_en};
                irq_mask_pkg::SEL_NONE:     next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Output registered once; edges of it set sticky bits
    always_comb begin
        next_ext_q   = ext_req;
        next_stat_en = stat_en;
        next_stat    = stat;
        if (req.wr && sel == irq_mask_pkg::SEL_STAT_EN) begin
            next_stat_en = req.wdata[1:0];
        end
        // Write one to clear; a new edge in the same cycle wins
        if (req.wr && sel == irq_mask_pkg::SEL_STAT) begin
            next_stat = stat & ~req.wdata[1:0];
        end
        if (ext_req && !ext_q) begin
            next_stat[`STAT_RISE_BIT] = 1'b1;
        end
        if (!ext_req && ext_q) begin
            next_stat[`STAT_FALL_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata   <= 32'h0000_0000;
            ext_q   <= 1'b0;
            stat    <= `STAT_RESET;
            stat_en <= `STAT_RESET;
        end else begin
            rdata   <= next_rdata;
            ext_q   <= next_ext_q;
            stat    <= next_stat;
            stat_en <= next_stat_en;
        end
    end

    assign rdata_o   = rdata;
    assign ext_irq_o = ext_q;
    assign irq_o     = |(stat & stat_en);

    //======================================================================
    // Helper terms for the checks
    //======================================================================
    logic                     gate_on;    // Global gate bit of the mask
    logic [31:0]              paired;     // Events with their enable set
    logic                     rise_seen;  // Output about to rise
    logic                     fall_seen;  // Output about to fall
    logic                     stat_wr;    // Write to the status word
    logic                     stat_en_wr; // Write to the status mask
    logic                     mask_wr;    // Write at either alias

    // Plain nets, so properties stay short and readable
    assign gate_on    = mask[`GLOBAL_GATE_BIT];
    assign paired     = mask & event_i & `EVENT_IMPL;
    assign rise_seen  = ext_req && !ext_q;
    assign fall_seen  = !ext_req && ext_q;
    assign stat_wr    = req.wr && sel == irq_mask_pkg::SEL_STAT;
    assign stat_en_wr = req.wr && sel == irq_mask_pkg::SEL_STAT_EN;
    // Either alias counts; an unmapped write must not touch the mask
    assign mask_wr    = req.wr && (sel == irq_mask_pkg::SEL_MASK_SET
                                   || sel == irq_mask_pkg::SEL_MASK_CLR);

    //======================================================================
    // Checks
    //======================================================================
    sequence mask_read_s;
        req.rd && (sel == irq_mask_pkg::SEL_MASK_SET
                   || sel == irq_mask_pkg::SEL_MASK_CLR);
    endsequence
    // Either alias returns the one stored mask
    alias_read_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        mask_read_s |=> rdata_o == $past(mask))
        else $error("alias read differs from mask");
    // Gate closed: nothing reaches the pin, whatever else is set
    gate_off_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !gate_on |=> !ext_irq_o)
        else $error("interrupt with gate off");
    // Any enabled pair with the gate open raises the pin
    follow_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (gate_on && |paired) |=> ext_irq_o)
        else $error("interrupt missing");
    // Soft enable alone, without its event, stays quiet
    soft_only_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (mask == 32'hA000_0000 && !event_i[29]) |=> !ext_irq_o)
        else $error("soft request without event");
    // Reserved positions read as zero at both aliases
    reserved_read_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        mask_read_s |=> (rdata_o & ~`MASK_IMPL) == 32'h0000_0000)
        else $error("reserved bits read nonzero");

    //======================================================================
    // Event families, each against its own enable group
    //======================================================================
    // Gate open and the maker extra pair both set
    sequence maker_s;
        gate_on && |(paired & `MAKER_GRP);
    endsequence
    // Gate open and the software raised pair both set
    sequence soft_s;
        gate_on && |(paired & `SOFT_GRP);
    endsequence
    // Gate open and one of the four fault pairs set
    sequence fault_s;
        gate_on && |(paired & `FAULT_GRP);
    endsequence
    // Gate open and one of the cycle timer pairs set
    sequence timer_s;
        gate_on && |(paired & `TIMER_GRP);
    endsequence
    // Gate open and one of the line and node pairs set
    sequence link_s;
        gate_on && |(paired & `LINK_GRP);
    endsequence
    // Gate open and one of the two host error pairs set
    sequence error_s;
        gate_on && |(paired & `ERROR_GRP);
    endsequence
    // Gate open and one of the eight DMA pairs set
    sequence dma_s;
        gate_on && |(paired & `DMA_GRP);
    endsequence
    // Maker extra event reaches the pin a cycle later
    maker_evt_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        maker_s |=> ext_irq_o)
        else $error("maker extra event lost");
    // Software raised event reaches the pin a cycle later
    soft_evt_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        soft_s |=> ext_irq_o)
        else $error("software raised event lost");
    // Fault family reaches the pin a cycle later
    fault_evt_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        fault_s |=> ext_irq_o)
        else $error("fault event lost");
    // Cycle timer family reaches the pin a cycle later
    timer_evt_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        timer_s |=> ext_irq_o)
        else $error("cycle timer event lost");
    // Line and node family reaches the pin a cycle later
    link_evt_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        link_s |=> ext_irq_o)
        else $error("line event lost");
    // Host error family reaches the pin a cycle later
    error_evt_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        error_s |=> ext_irq_o)
        else $error("host error event lost");
    // DMA family reaches the pin a cycle later
    dma_evt_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        dma_s |=> ext_irq_o)
        else $error("dma event lost");

    //======================================================================
    // Pairing, read port and local status
    //======================================================================
    // No bit paired with its own enable: the pin stays low
    no_pair_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (paired == 32'h0000_0000) |=> !ext_irq_o)
        else $error("interrupt without a paired event");
    // Read data stand only in the cycle after a read
    rdata_idle_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !req.rd |=> rdata_o == 32'h0000_0000)
        else $error("read data without a read");
    // Unmapped reads return zero
    unmapped_rd_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (req.rd && sel == irq_mask_pkg::SEL_NONE)
        |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    // Read of the status word
    sequence stat_read_s;
        req.rd && sel == irq_mask_pkg::SEL_STAT;
    endsequence
    // Read of the status mask
    sequence stat_en_read_s;
        req.rd && sel == irq_mask_pkg::SEL_STAT_EN;
    endsequence
    // Output about to rise on the next edge
    sequence rise_s;
        rise_seen;
    endsequence
    // Output about to fall on the next edge
    sequence fall_s;
        fall_seen;
    endsequence
    // Status read returns the sticky bits as they stood
    rdata_stat_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        stat_read_s |=> rdata_o == {30'h0000_0000, $past(stat)})
        else $error("status read differs");
    // Status mask read returns the enables as they stood
    rdata_stat_en_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        stat_en_read_s |=> rdata_o == {30'h0000_0000, $past(stat_en)})
        else $error("status mask read differs");
    // A rising output always leaves its sticky bit set
    rise_sets_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        rise_s |=> stat[`STAT_RISE_BIT])
        else $error("rise not recorded");
    // A falling output always leaves its sticky bit set
    fall_sets_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        fall_s |=> stat[`STAT_FALL_BIT])
        else $error("fall not recorded");
    // Writing one clears the rise bit when no new rise competes
    rise_clear_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (stat_wr && req.wdata[`STAT_RISE_BIT] && !rise_seen)
        |=> !stat[`STAT_RISE_BIT])
        else $error("rise bit not cleared");
    // Writing one clears the fall bit when no new fall competes
    fall_clear_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (stat_wr && req.wdata[`STAT_FALL_BIT] && !fall_seen)
        |=> !stat[`STAT_FALL_BIT])
        else $error("fall bit not cleared");
    // Without an edge or a write the sticky bits hold
    stat_hold_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (!stat_wr && !rise_seen && !fall_seen) |=> $stable(stat))
        else $error("status changed by itself");
    // Status mask changes only when written
    stat_en_hold_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !stat_en_wr |=> $stable(stat_en))
        else $error("status mask changed by itself");
    // A status mask write lands whole in the next cycle
    stat_en_wr_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        stat_en_wr |=> stat_en == $past(req.wdata[1:0]))
        else $error("status mask write lost");
    // Mask changes only on a write at one of its aliases
    mask_hold_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !mask_wr |=> $stable(mask))
        else $error("mask changed without a write");
endmodule // host_link_irq_mask_gate

// ==== rtl/irq_mask_regs.svh ====
`ifndef IRQ_MASK_REGS_SVH
`define IRQ_MASK_REGS_SVH
//==========================================================================
// Contract
// - Both aliases read the same mask
// - Bit 31 gates the external interrupt
// - Other mask bits pair with event bits
// - Bit 30 enables the maker extra event
// - Bit 29 enables the software raised event
// - Bit 28 reads zero, ignores writes
// - Bits 14 to 10 read zero
// - Bits 27 to 24 enable four faults
// - Bits 23 to 20 enable cycle timer events
// - Bits 19 to 15 enable link events
// - Bits 9 and 8 enable error events
// - Bits 7 to 0 enable DMA events
//==========================================================================
// Register offsets (byte addresses)
`define MASK_SET_OFS      8'h88
`define MASK_CLR_OFS      8'h8C
`define STAT_OFS          8'hC0
`define STAT_EN_OFS       8'hC4
// Field positions
`define GLOBAL_GATE_BIT   5'h1F
// Implemented mask bits: 31..29, 27..15, 9..0
`define MASK_IMPL         32'hEFFF_83FF
// Event bits that may raise a request (all implemented bits but the gate)
`define EVENT_IMPL        32'h6FFF_83FF
// Event families, one enable group each
`define MAKER_GRP         32'h4000_0000
`define SOFT_GRP          32'h2000_0000
`define FAULT_GRP         32'h0F00_0000
`define TIMER_GRP         32'h00F0_0000
`define LINK_GRP          32'h000F_8000
`define ERROR_GRP         32'h0000_0300
`define DMA_GRP           32'h0000_00FF
// Reset values
`define MASK_RESET        32'h0000_0000
`define STAT_RESET        2'h0
// Own status bits
`define STAT_RISE_BIT     1'h0
`define STAT_FALL_BIT     1'h1
`endif

// ==== rtl/irq_mask_pkg.sv ====
//==========================================================================
// Types shared by the mask gate files
//==========================================================================
package irq_mask_pkg;
    // Register bus request
    typedef struct packed {
        logic [7:0]  addr;   // Byte address
        logic [31:0] wdata;  // Write data
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
    } bus_req_s;
    // Register selected by a decode
    typedef enum logic [2:0] {
        SEL_NONE, SEL_MASK_SET, SEL_MASK_CLR, SEL_STAT, SEL_STAT_EN
    } reg_sel_e;
endpackage

// ==== rtl/mask_store.sv ====
`timescale 1ns/1ps
`include "irq_mask_regs.svh"
//==========================================================================
// Set/clear mask storage
//==========================================================================
module mask_store (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Alias strobes with write data
    input  wire logic        set_i,
    input  wire logic        clr_i,
    input  wire logic [31:0] wdata_i,
    // Stored mask
    output logic      [31:0] mask_o
);
    logic [31:0] mask;       // Mask flops
    logic [31:0] next_mask;  // Next mask

    // Ones set or clear; zeros keep; reserved bits never stored
    always_comb begin
        next_mask = mask;
        if (set_i) begin
            next_mask = mask | wdata_i;
        end
        if (clr_i) begin
            next_mask = mask & ~wdata_i;
        end
        next_mask = next_mask & `MASK_IMPL;
    end

    // Register only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask <= `MASK_RESET;
        end else begin
            mask <= next_mask;
        end
    end

    assign mask_o = mask;

    // Reserved bits never hold a one
    rsvd_zero_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (mask & ~`MASK_IMPL) == 32'h0000_0000)
        else $error("reserved mask bit set");
    // A set write lands one cycle later
    set_lands_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        set_i |=> ((mask & ($past(wdata_i) & `MASK_IMPL))
                   == ($past(wdata_i) & `MASK_IMPL)))
        else $error("set alias did not set");
    // A clear write empties those bits
    clr_lands_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        clr_i |=> ((mask & $past(wdata_i)) == 32'h0000_0000))
        else $error("clear alias did not clear");
    // Zero written bits keep their value
    zero_keeps_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (set_i || clr_i) |=> ((mask & ~$past(wdata_i))
                   == ($past(mask) & ~$past(wdata_i))))
        else $error("unwritten mask bit changed");
endmodule // mask_store

// ==== rtl/irq_gate.sv ====
`timescale 1ns/1ps
`include "irq_mask_regs.svh"
//==========================================================================
// Combine events with mask and global gate
//==========================================================================
module irq_gate (
    // Inputs
    input  wire logic [31:0] mask_i,
    input  wire logic [31:0] event_i,
    // Request
    output logic             req_o
);
    logic [31:0] pend;  // Enabled events
    logic        gate;  // Global gate bit

    // Bit for bit pairing, gate and reserved positions excluded
    assign pend = mask_i & event_i & `EVENT_IMPL;
    assign gate = mask_i[`GLOBAL_GATE_BIT];
    // Gate off wins over every other bit
    assign req_o = gate & (|pend);
endmodule // irq_gate

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`include "irq_mask_regs.svh"
//==========================================================================
// Bench for the interrupt mask stage
//==========================================================================
`define CHECK(nm, exp, got) \
    begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
    logic        clk_i     = 1'b0;   // 25 MHz clock
    logic        reset_n_i = 1'b0;   // Active low reset
    logic [7:0]  addr_i    = 8'h00;  // Register address
    logic [31:0] wdata_i   = 32'h0;  // Write data
    logic        wr_i      = 1'b0;   // Write strobe
    logic        rd_i      = 1'b0;   // Read strobe
    logic [31:0] event_i   = 32'h0;  // Event register contents
    logic [31:0] rdata_o;            // Read data
    logic        ext_irq_o;          // External request
    logic        irq_o;              // Local status request
    int          n_errors        = 0;
    int          samples_checked = 0;
    logic [31:0] rd_val;             // Last read result
    //======================================================================
    // Clock, device, watchdog
    //======================================================================
    always #20 clk_i = ~clk_i;
    host_link_irq_mask_gate DUT (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .event_i(event_i), .ext_irq_o(ext_irq_o), .irq_o(irq_o));
    // Whole run needs well under a thousand cycles
    initial begin
        #(3000 * 40);
        n_errors++;
        give_verdict();
    end
    //======================================================================
    // Bus tasks
    //======================================================================
    // One write cycle, strobe released after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 rd_val = rdata_o;
    endtask
    // Registered output lags its cause by one cycle
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    //======================================================================
    // Scenarios
    //======================================================================
    // Aliases, reserved bits, set and clear semantics
    task automatic alias_access();
        rd(`MASK_SET_OFS);
        `CHECK("mask after reset", `MASK_RESET, rd_val)
        wr(`MASK_SET_OFS, 32'hFFFF_FFFF);
        rd(`MASK_SET_OFS);
        `CHECK("set alias read", `MASK_IMPL, rd_val)
        rd(`MASK_CLR_OFS);
        `CHECK("clear alias read", `MASK_IMPL, rd_val)
        wr(`MASK_CLR_OFS, 32'h8000_0001);
        wr(`MASK_SET_OFS, 32'h0);
        rd(`MASK_CLR_OFS);
        `CHECK("after clear", 32'h6FFF_83FE, rd_val)
        @(posedge clk_i);
        #1;
        `CHECK("read data gone", 32'h0, rdata_o)
        wr(8'h40, 32'h0);
        rd(8'h40);
        `CHECK("unmapped read", 32'h0, rd_val)
        rd(`MASK_SET_OFS);
        `CHECK("unmapped write", 32'h6FFF_83FE, rd_val)
        `CHECK("gate off", 1'b0, ext_irq_o)
    endtask
    // Each implemented bit but the gate pairs with its own event only
    task automatic gate_bits();
        logic [31:0] m;
        for (int b = 0; b < 31; b++) begin
            m = 32'h1 << b;
            if ((m & `MASK_IMPL) != 32'h0) begin
                wr(`MASK_CLR_OFS, 32'hFFFF_FFFF);
                wr(`MASK_SET_OFS, m | 32'h8000_0000);
                @(posedge clk_i);
                event_i <= ~m;
                settle();
                `CHECK("other events", 1'b0, ext_irq_o)
                @(posedge clk_i);
                event_i <= m;
                settle();
                `CHECK("paired event", 1'b1, ext_irq_o)
                wr(`MASK_CLR_OFS, 32'h8000_0000);
                settle();
                `CHECK("global gate", 1'b0, ext_irq_o)
            end
        end
    endtask
    // Local status: raise, mask, clear
    task automatic status_irq();
        wr(`STAT_OFS, 32'h3);
        wr(`STAT_EN_OFS, 32'h1);
        rd(`STAT_EN_OFS);
        `CHECK("status mask", 32'h1, rd_val)
        rd(`STAT_OFS);
        `CHECK("status cleared", 32'h0, rd_val)
        `CHECK("local idle", 1'b0, irq_o)
        wr(`MASK_SET_OFS, 32'h8000_0000);
        repeat (3) @(posedge clk_i);
        #1;
        `CHECK("ext raised", 1'b1, ext_irq_o)
        `CHECK("local raised", 1'b1, irq_o)
        rd(`STAT_OFS);
        `CHECK("rise status", 32'h1, rd_val)
        wr(`STAT_EN_OFS, 32'h0);
        `CHECK("local masked", 1'b0, irq_o)
        wr(`STAT_EN_OFS, 32'h1);
        wr(`STAT_OFS, 32'h1);
        `CHECK("local cleared", 1'b0, irq_o)
    endtask
    //======================================================================
    // Verdict and main sequence
    //======================================================================
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        alias_access();
        gate_bits();
        status_irq();
        give_verdict();
    end
endmodule // testbench
